// >>> common/pwr_ctl_pkg.sv
/*
 * package for the codec power-mode and autocalibration controller:
 * offsets, fields, reset values, timing, states.
 * assumes a 20 MHz pclk and a one-cycle sample-rate strobe from outside.
 */
`default_nettype none

package pwr_ctl_pkg;
   // ---------------------------------------------------------------
   // register map (byte addresses, one word each)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_IFACE_CFG = 8'h00;
   localparam logic [7:0] ADDR_PWR_CTL = 8'h04;
   localparam logic [7:0] ADDR_TOTAL_PWR = 8'h08;
   localparam logic [7:0] ADDR_TEST_INIT = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_OFFSET = 8'h14;

   // interface configuration fields
   localparam int BIT_MODE_CHANGE = 0;
   localparam int BIT_AUTOCAL_REQ = 1;
   localparam int BIT_CAPTURE_EN = 2;
   localparam int BIT_PLAYBACK_EN = 3;
   // power-down control fields
   localparam int BIT_CAPTURE_OFF = 0;
   localparam int BIT_PLAYBACK_OFF = 1;
   localparam int BIT_MIXER_OFF = 2;
   // total power-down field
   localparam int BIT_TOTAL_OFF = 0;
   // test and initialization field
   localparam int BIT_AUTOCAL_BUSY = 5;

   localparam logic [3:0] IFACE_CFG_RST = 4'h1; // starts in mode change
   localparam logic [31:0] BUSY_READ_VALUE = 32'h0000_0080;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 20_000_000;
   localparam int INIT_TIME_MS = 512;
   localparam int INIT_CYCLES = INIT_TIME_MS * (CLK_HZ / 1000);
   localparam int EXIT_SAMPLES = 1;
   localparam int RESTORE_SAMPLES = 128;
   localparam int AUTOCAL_SAMPLES = 384;
   localparam int SAMPLE_CNT_W = 9;
   localparam int INIT_CNT_W = 24;

   // operating mode decoded from the power bits
   typedef enum logic [3:0] {
      MODE_OPERATING = 4'h0,
      MODE_TOTAL = 4'h3,
      MODE_STANDBY = 4'h4,
      MODE_MIXER_OFF = 4'h5,
      MODE_MIXER_ONLY = 4'h6,
      MODE_CAPTURE_OFF = 4'h7,
      MODE_PLAYBACK_OFF = 4'h8
   } pwr_mode_e;

   // main sequence, gray coded along init -> modechg -> cal -> run
   typedef enum logic [2:0] {
      ST_INIT = 3'b000,
      ST_MODECHG = 3'b001,
      ST_CAL = 3'b011,
      ST_RUN = 3'b010,
      ST_RESTORE = 3'b110,
      ST_TOTAL = 3'b111
   } seq_state_e;
endpackage : pwr_ctl_pkg

`default_nettype wire

// >>> core/offset_store.sv
/*
 * small register memory holding the converter offset compensation words.
 * assumes writes come only from calibration; read data registered.
 */
`default_nettype none

module offset_store (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // write side
   input wire logic wr_en,
   input wire logic [1:0] wr_addr,
   input wire logic [15:0] wr_data,
   // read side
   input wire logic [1:0] rd_addr,
   output logic [15:0] rd_data
);
   logic [15:0] mem_q [4];
   logic [15:0] mem_d [4];
   logic [15:0] rd_d;
   logic [15:0] rd_q;

   // ---------------------------------------------------------------
   // storage: each entry only changes on its own write
   // ---------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_entry
         always_comb begin
            mem_d[gi] = mem_q[gi];
            if (wr_en && (wr_addr == 2'(gi))) begin
               mem_d[gi] = wr_data;
            end
         end
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               mem_q[gi] <= 16'h0000;
            end else begin
               mem_q[gi] <= mem_d[gi];
            end
         end
      end
   endgenerate

   // registered read port
   always_comb begin
      rd_d = mem_q[rd_addr];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_q <= 16'h0000;
      end else begin
         rd_q <= rd_d;
      end
   end
   assign rd_data = rd_q;
endmodule : offset_store

`default_nettype wire

// >>> core/codec_power_ctl.sv
/*
 * power-mode and autocalibration controller with an APB register slave.
 * assumes synchronous sample_tick and sleep pin;
 * presetn is the reset pin.
 */
// Behaviour
// - total shutdown only accepted while mode change state is active.
// - clearing total shutdown reruns full initialization of about 512 ms.
// - total shutdown turns everything off, flushes both FIFOs, bus stays alive.
// - software power states entered by writing ones, no mode change needed.
// - capture and mixer off gives standby: mute, flush both FIFOs.
// - mixer off alone kills mixer and playback, flushes playback, mutes.
// - capture and playback off keeps mixer only, flushes both FIFOs.
// - capture off stops capture engine and gain stage, flushes capture FIFO.
// - playback off suspends playback engine and flushes playback FIFO.
// - software power-down keeps state; clearing in run restores over the restore state without reinitializing.
// - leave power-down within one sample, unmute after 128 more.
// - first mode change exit after reset always calibrates.
// - later mode change exits calibrate only when request bit set.
// - without calibration, stored offset values stay unchanged.
// - busy flag high for 384 sample periods during calibration.
// - transfers enabled during calibration wait until it completes.
// - during calibration capture data invalid, playback samples ignored.
// - while initializing writes dropped, reads return 80h.
// - sleep pin and reset override every software power state.
// - after power-up the device starts in mode change state.
`default_nettype none

module codec_power_ctl #(
   parameter int INIT_CYCLES = pwr_ctl_pkg::INIT_CYCLES
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // sample rate strobe and pins
   input wire logic sample_tick,
   input wire logic hw_sleep_pin_n,
   input wire logic [15:0] cal_offset_in,
   // analog and engine controls
   output logic adc_on,
   output logic dac_on,
   output logic mixer_on,
   output logic vref_on,
   output logic pga_on,
   output logic outputs_mute,
   output logic capture_flush,
   output logic playback_flush,
   output logic capture_run,
   output logic playback_run,
   output logic capture_data_valid
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   pwr_ctl_pkg::seq_state_e state_q, state_d;
   logic [3:0] cfg_q, cfg_d;
   logic [2:0] pwr_q, pwr_d;
   logic total_q, total_d;
   logic first_cal_q, first_cal_d;
   logic [23:0] init_cnt_q, init_cnt_d;
   logic [8:0] samp_cnt_q, samp_cnt_d;
   logic [31:0] rdata_q, rdata_d;
   logic ready_q, ready_d;
   logic err_q, err_d;
   logic [1:0] cal_idx_q, cal_idx_d;
   // registered control outputs
   logic adc_on_q, dac_on_q, mixer_on_q, vref_on_q, pga_on_q, mute_q;
   logic cflush_q, pflush_q, crun_q, prun_q, cvalid_q;
   logic adc_on_d, dac_on_d, mixer_on_d, vref_on_d, pga_on_d, mute_d;
   logic cflush_d, pflush_d, crun_d, prun_d, cvalid_d;

   pwr_ctl_pkg::pwr_mode_e mode;
   logic [15:0] offset_rd;
   logic acc, wr_acc, rd_acc, initializing, cal_wr;

   localparam logic [23:0] INIT_LAST = 24'(INIT_CYCLES - 1);
   localparam logic [8:0] AUTOCAL_LAST = 9'(pwr_ctl_pkg::AUTOCAL_SAMPLES - 1);
   localparam logic [8:0] RESTORE_LAST =
      9'(pwr_ctl_pkg::RESTORE_SAMPLES + pwr_ctl_pkg::EXIT_SAMPLES - 1);

   assign acc = psel && penable;
   assign wr_acc = acc && pwrite;
   assign rd_acc = acc && !pwrite;
   assign initializing = (state_q == pwr_ctl_pkg::ST_INIT);
   // one offset word per sample in the first four samples of calibration
   assign cal_wr = (state_q == pwr_ctl_pkg::ST_CAL) && sample_tick &&
      (samp_cnt_q < 9'h004);

   // offset compensation memory, only written by calibration
   offset_store u_offsets (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(cal_wr),
      .wr_addr(samp_cnt_q[1:0]),
      .wr_data(cal_offset_in),
      .rd_addr(cal_idx_q),
      .rd_data(offset_rd)
   );

   // ---------------------------------------------------------------
   // mode decode; total shutdown wins over the other bits
   // ---------------------------------------------------------------
   always_comb begin
      if (total_q) begin
         mode = pwr_ctl_pkg::MODE_TOTAL;
      end else begin
         case ({pwr_q[pwr_ctl_pkg::BIT_CAPTURE_OFF], pwr_q[pwr_ctl_pkg::BIT_PLAYBACK_OFF],
               pwr_q[pwr_ctl_pkg::BIT_MIXER_OFF]})
            3'b101, 3'b111: mode = pwr_ctl_pkg::MODE_STANDBY;
            3'b001, 3'b011: mode = pwr_ctl_pkg::MODE_MIXER_OFF;
            3'b110: mode = pwr_ctl_pkg::MODE_MIXER_ONLY;
            3'b100: mode = pwr_ctl_pkg::MODE_CAPTURE_OFF;
            3'b010: mode = pwr_ctl_pkg::MODE_PLAYBACK_OFF;
            default: mode = pwr_ctl_pkg::MODE_OPERATING;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // register writes and sequence
   // ---------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      cfg_d = cfg_q;
      pwr_d = pwr_q;
      total_d = total_q;
      first_cal_d = first_cal_q;
      init_cnt_d = init_cnt_q;
      samp_cnt_d = samp_cnt_q;
      cal_idx_d = cal_idx_q;
      // host writes; all dropped during initialization
      if (wr_acc && !initializing) begin
         case (paddr)
            pwr_ctl_pkg::ADDR_IFACE_CFG: cfg_d = pwdata[3:0];
            pwr_ctl_pkg::ADDR_PWR_CTL: pwr_d = pwdata[2:0];
            pwr_ctl_pkg::ADDR_TOTAL_PWR: begin
               // setting only takes effect inside mode change
               if (pwdata[pwr_ctl_pkg::BIT_TOTAL_OFF] && cfg_q[pwr_ctl_pkg::BIT_MODE_CHANGE]) begin
                  total_d = 1'b1;
               end else if (!pwdata[pwr_ctl_pkg::BIT_TOTAL_OFF] && total_q) begin
                  total_d = 1'b0;
                  state_d = pwr_ctl_pkg::ST_INIT;
                  init_cnt_d = 24'h000000;
               end
            end
            pwr_ctl_pkg::ADDR_OFFSET: cal_idx_d = pwdata[1:0];
            default: ;
         endcase
      end
      // software power-down cleared in run: restore over 1 + 128 samples
      if (state_q == pwr_ctl_pkg::ST_RUN && pwr_q != 3'b000 && pwr_d == 3'b000) begin
         state_d = pwr_ctl_pkg::ST_RESTORE;
         samp_cnt_d = 9'h000;
      end
      case (state_q)
         pwr_ctl_pkg::ST_INIT: begin
            init_cnt_d = init_cnt_q + 24'h000001;
            if (init_cnt_q == INIT_LAST) begin
               state_d = pwr_ctl_pkg::ST_MODECHG;
               // initialization restores the default interface config and power-down contents; offset index kept
               cfg_d = pwr_ctl_pkg::IFACE_CFG_RST;
               pwr_d = 3'b000;
            end
         end
         pwr_ctl_pkg::ST_MODECHG: begin
            if (total_q) begin
               state_d = pwr_ctl_pkg::ST_TOTAL;
            end else if (!cfg_d[pwr_ctl_pkg::BIT_MODE_CHANGE]) begin
               samp_cnt_d = 9'h000;
               if (first_cal_q || cfg_d[pwr_ctl_pkg::BIT_AUTOCAL_REQ]) begin
                  state_d = pwr_ctl_pkg::ST_CAL;
                  first_cal_d = 1'b0;
               end else begin
                  state_d = pwr_ctl_pkg::ST_RUN;
               end
            end
         end
         pwr_ctl_pkg::ST_CAL: begin
            if (sample_tick) begin
               samp_cnt_d = samp_cnt_q + 9'h001;
               if (samp_cnt_q == AUTOCAL_LAST) begin
                  state_d = pwr_ctl_pkg::ST_RUN;
               end
            end
         end
         pwr_ctl_pkg::ST_RUN: begin
            if (cfg_d[pwr_ctl_pkg::BIT_MODE_CHANGE]) begin
               state_d = pwr_ctl_pkg::ST_MODECHG;
            end
         end
         pwr_ctl_pkg::ST_RESTORE: begin
            if (sample_tick) begin
               samp_cnt_d = samp_cnt_q + 9'h001;
               if (samp_cnt_q == RESTORE_LAST) begin
                  state_d = pwr_ctl_pkg::ST_RUN;
               end
            end
         end
         pwr_ctl_pkg::ST_TOTAL: ; // left by the clear above or the sleep pin below
         default: state_d = pwr_ctl_pkg::ST_INIT;
      endcase
      // sleep pin forces a full restart, like reset
      if (!hw_sleep_pin_n) begin
         state_d = pwr_ctl_pkg::ST_INIT;
         init_cnt_d = 24'h000000;
         total_d = 1'b0;
         first_cal_d = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // apb read path and answer; zero wait states
   // ---------------------------------------------------------------
   always_comb begin
      rdata_d = 32'h0000_0000;
      err_d = 1'b0;
      ready_d = psel && !penable;
      if (psel && !penable) begin
         if (initializing) begin
            rdata_d = pwr_ctl_pkg::BUSY_READ_VALUE;
         end else begin
            case (paddr)
               pwr_ctl_pkg::ADDR_IFACE_CFG: rdata_d = {28'h0, cfg_q};
               pwr_ctl_pkg::ADDR_PWR_CTL: rdata_d = {29'h0, pwr_q};
               pwr_ctl_pkg::ADDR_TOTAL_PWR: rdata_d = {31'h0, total_q};
               pwr_ctl_pkg::ADDR_TEST_INIT:
                  rdata_d = 32'((state_q == pwr_ctl_pkg::ST_CAL)) <<
                     pwr_ctl_pkg::BIT_AUTOCAL_BUSY;
               pwr_ctl_pkg::ADDR_STATUS: rdata_d = {25'h0, state_q, mode};
               pwr_ctl_pkg::ADDR_OFFSET: rdata_d = {16'h0, offset_rd};
               default: err_d = 1'b1;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // control outputs from mode and sequence
   // ---------------------------------------------------------------
   always_comb begin
      logic live, cal, restoring;
      live = (state_q == pwr_ctl_pkg::ST_RUN) || (state_q == pwr_ctl_pkg::ST_RESTORE);
      cal = (state_q == pwr_ctl_pkg::ST_CAL);
      restoring = (state_q == pwr_ctl_pkg::ST_RESTORE);
      adc_on_d = live || cal;
      dac_on_d = live || cal;
      mixer_on_d = live || cal;
      pga_on_d = live || cal;
      vref_on_d = (state_q != pwr_ctl_pkg::ST_TOTAL) && (state_q != pwr_ctl_pkg::ST_INIT);
      // restore keeps outputs muted until the 128 samples have passed
      mute_d = !live || restoring;
      cflush_d = !live;
      pflush_d = !live;
      case (mode)
         pwr_ctl_pkg::MODE_TOTAL: begin
            adc_on_d = 1'b0;
            dac_on_d = 1'b0;
            mixer_on_d = 1'b0;
            pga_on_d = 1'b0;
            vref_on_d = 1'b0;
            mute_d = 1'b1;
            cflush_d = 1'b1;
            pflush_d = 1'b1;
         end
         pwr_ctl_pkg::MODE_STANDBY: begin
            adc_on_d = 1'b0;
            dac_on_d = 1'b0;
            mixer_on_d = 1'b0;
            pga_on_d = 1'b0;
            mute_d = 1'b1;
            cflush_d = 1'b1;
            pflush_d = 1'b1;
         end
         pwr_ctl_pkg::MODE_MIXER_OFF: begin
            dac_on_d = 1'b0;
            mixer_on_d = 1'b0;
            mute_d = 1'b1;
            pflush_d = 1'b1;
         end
         pwr_ctl_pkg::MODE_MIXER_ONLY: begin
            adc_on_d = 1'b0;
            dac_on_d = 1'b0;
            pga_on_d = 1'b0;
            cflush_d = 1'b1;
            pflush_d = 1'b1;
         end
         pwr_ctl_pkg::MODE_CAPTURE_OFF: begin
            adc_on_d = 1'b0;
            pga_on_d = 1'b0;
            cflush_d = 1'b1;
         end
         pwr_ctl_pkg::MODE_PLAYBACK_OFF: begin
            dac_on_d = 1'b0;
            pflush_d = 1'b1;
         end
         default: ;
      endcase
      // transfers only run outside calibration; enables wait for it
      crun_d = live && adc_on_d && cfg_q[pwr_ctl_pkg::BIT_CAPTURE_EN];
      prun_d = live && dac_on_d && cfg_q[pwr_ctl_pkg::BIT_PLAYBACK_EN];
      cvalid_d = live && adc_on_d;
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= pwr_ctl_pkg::ST_INIT;
         cfg_q <= pwr_ctl_pkg::IFACE_CFG_RST;
         pwr_q <= 3'b000;
         total_q <= 1'b0;
         first_cal_q <= 1'b1;
         init_cnt_q <= 24'h000000;
         samp_cnt_q <= 9'h000;
         cal_idx_q <= 2'h0;
         rdata_q <= 32'h0000_0000;
         ready_q <= 1'b0;
         err_q <= 1'b0;
         adc_on_q <= 1'b0;
         dac_on_q <= 1'b0;
         mixer_on_q <= 1'b0;
         vref_on_q <= 1'b0;
         pga_on_q <= 1'b0;
         mute_q <= 1'b1;
         cflush_q <= 1'b1;
         pflush_q <= 1'b1;
         crun_q <= 1'b0;
         prun_q <= 1'b0;
         cvalid_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cfg_q <= cfg_d;
         pwr_q <= pwr_d;
         total_q <= total_d;
         first_cal_q <= first_cal_d;
         init_cnt_q <= init_cnt_d;
         samp_cnt_q <= samp_cnt_d;
         cal_idx_q <= cal_idx_d;
         rdata_q <= rdata_d;
         ready_q <= ready_d;
         err_q <= err_d;
         adc_on_q <= adc_on_d;
         dac_on_q <= dac_on_d;
         mixer_on_q <= mixer_on_d;
         vref_on_q <= vref_on_d;
         pga_on_q <= pga_on_d;
         mute_q <= mute_d;
         cflush_q <= cflush_d;
         pflush_q <= pflush_d;
         crun_q <= crun_d;
         prun_q <= prun_d;
         cvalid_q <= cvalid_d;
      end
   end

   assign prdata = rdata_q;
   assign pready = ready_q;
   assign pslverr = err_q;
   assign adc_on = adc_on_q;
   assign dac_on = dac_on_q;
   assign mixer_on = mixer_on_q;
   assign vref_on = vref_on_q;
   assign pga_on = pga_on_q;
   assign outputs_mute = mute_q;
   assign capture_flush = cflush_q;
   assign playback_flush = pflush_q;
   assign capture_run = crun_q;
   assign playback_run = prun_q;
   assign capture_data_valid = cvalid_q;
endmodule : codec_power_ctl

`default_nettype wire

// >>> sim/codec_power_ctl_props.sv
/*
 * checker for the power controller: apb answer, power-mode outputs.
 * assumes it is bound to codec_power_ctl, ports only.
 */
`default_nettype none

module codec_power_ctl_props #(
   parameter int INIT_CYCLES = 50
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb and pins
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic hw_sleep_pin_n,
   // power and engine controls
   input wire logic adc_on,
   input wire logic dac_on,
   input wire logic mixer_on,
   input wire logic vref_on,
   input wire logic pga_on,
   input wire logic outputs_mute,
   input wire logic capture_flush,
   input wire logic playback_flush,
   input wire logic capture_run,
   input wire logic playback_run,
   input wire logic capture_data_valid
);
   // -----------------------------------------------------------------
   // properties
   // -----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // zero-wait answer, one cycle wide
   access_ready_a: assert property (
      (psel && !penable) ##1 (psel && penable) |-> pready) else $error("no ready in access");
   ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
   err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
   // power-state relations
   standby_flush_a: assert property (
      !adc_on && !mixer_on |-> capture_flush && playback_flush) else $error("standby not flushed");
   mixer_off_a: assert property (
      !mixer_on |-> !dac_on && outputs_mute && playback_flush) else $error("mixer off unmuted");
   capture_off_a: assert property (
      !adc_on |-> !pga_on && capture_flush && !capture_run) else $error("capture left running");
   playback_off_a: assert property (
      !dac_on |-> playback_flush && !playback_run) else $error("playback left running");
   total_off_a: assert property (
      !vref_on |-> !adc_on && !dac_on && !mixer_on && capture_flush && playback_flush)
      else $error("converter on without reference");
   sleep_pin_a: assert property (
      $fell(hw_sleep_pin_n) |-> ##[1:3] (!vref_on && outputs_mute)) else $error("sleep ignored");
   valid_data_a: assert property (
      capture_data_valid |-> adc_on && !capture_flush) else $error("capture data while stopped");

   // covers
   cover property (pready && pslverr);
   cover property (adc_on && !mixer_on);
   cover property ($rose(capture_run));
endmodule : codec_power_ctl_props

bind codec_power_ctl codec_power_ctl_props #(.INIT_CYCLES(INIT_CYCLES)) props_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .hw_sleep_pin_n(hw_sleep_pin_n), .adc_on(adc_on), .dac_on(dac_on),
   .mixer_on(mixer_on), .vref_on(vref_on), .pga_on(pga_on), .outputs_mute(outputs_mute),
   .capture_flush(capture_flush), .playback_flush(playback_flush),
   .capture_run(capture_run), .playback_run(playback_run),
   .capture_data_valid(capture_data_valid));

`default_nettype wire

// >>> sim/tb_codec_power_ctl.sv
/*
 * bench for the power controller: apb master, sample strobe, read queue.
 * assumes only a short init parameter.
 */
`default_nettype none

module tb_codec_power_ctl;
   timeunit 1ns;
   timeprecision 1ns;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   localparam logic [32:0] ALL = 33'h1FFFFFFFF;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sample_tick, hw_sleep_pin_n;
   logic adc_on, dac_on, mixer_on, vref_on, pga_on, outputs_mute, capture_flush;
   logic playback_flush, capture_run, playback_run, capture_data_valid;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] cal_offset_in, v1;
   logic [32:0] exp_q[$];
   logic [32:0] mask_q[$];
   logic [1:0] div_q;
   logic [9:0] mtab [6];
   int fail_count, check_count, i;
   integer seed = 32'h8E34DCB4;

   codec_power_ctl #(.INIT_CYCLES(50)) dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sample_tick(sample_tick), .hw_sleep_pin_n(hw_sleep_pin_n),
      .cal_offset_in(cal_offset_in), .adc_on(adc_on), .dac_on(dac_on), .mixer_on(mixer_on),
      .vref_on(vref_on), .pga_on(pga_on), .outputs_mute(outputs_mute),
      .capture_flush(capture_flush), .playback_flush(playback_flush),
      .capture_run(capture_run), .playback_run(playback_run),
      .capture_data_valid(capture_data_valid));

   // ---------------------------------------------------------------
   // clock, sample strobe every fourth cycle
   // ---------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      div_q <= div_q + 2'h1;
      sample_tick <= (div_q == 2'h3);
   end

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic test_done();
      if (fail_count == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : test_done

   // request held until pready is sampled high
   task automatic apb(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= we;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdx(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
      exp_q.push_back(e & m);
      mask_q.push_back(m);
      apb(1'b0, a, 32'h0);
   endtask : rdx

   task automatic ticks(input int n);
      repeat (n) @(posedge pclk iff sample_tick);
   endtask : ticks

   // poll until not busy; gives up after 100 reads
   task automatic wait_init();
      rd = 32'h80;
      for (int k = 0; k < 100 && rd === 32'h80; k++) rdx(pwr_ctl_pkg::ADDR_TEST_INIT, 0, 0);
   endtask : wait_init

   task automatic cal_check();
      rdx(pwr_ctl_pkg::ADDR_TEST_INIT, 33'h20, 33'h20);
      ticks(378);
      rdx(pwr_ctl_pkg::ADDR_TEST_INIT, 33'h20, 33'h20);
      ticks(8);
      rdx(pwr_ctl_pkg::ADDR_TEST_INIT, 33'h0, 33'h20);
   endtask : cal_check

   // reads compared oldest first
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
         check({pslverr, prdata} & mask_q[0], exp_q[0]);
         void'(exp_q.pop_front());
         void'(mask_q.pop_front());
      end
   end

   // watchdog, far beyond the whole sequence
   initial begin
      repeat (30000) @(posedge pclk);
      fail_count++;
      test_done();
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, hw_sleep_pin_n, div_q} = 7'h04;
      {paddr, pwdata, sample_tick} = 41'h0;
      cal_offset_in = 16'($random(seed));
      mtab = '{{3'h5, 4'h4, 3'h0}, {3'h7, 4'h4, 3'h0}, {3'h4, 4'h5, 3'h4},
               {3'h3, 4'h6, 3'h1}, {3'h1, 4'h7, 3'h3}, {3'h2, 4'h8, 3'h5}};
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rdx(pwr_ctl_pkg::ADDR_STATUS, 33'h80, ALL);
      apb(1'b1, pwr_ctl_pkg::ADDR_IFACE_CFG, 32'hE);
      wait_init();
      rdx(pwr_ctl_pkg::ADDR_IFACE_CFG, 33'h1, 33'hF);
      rdx(pwr_ctl_pkg::ADDR_STATUS, 33'h10, 33'h7F);
      rdx(8'h3C, 33'h100000000, 33'h100000000);
      apb(1'b1, pwr_ctl_pkg::ADDR_PWR_CTL, 32'h2);
      apb(1'b1, pwr_ctl_pkg::ADDR_TOTAL_PWR, 32'h1);
      rdx(pwr_ctl_pkg::ADDR_STATUS, 33'h73, 33'h7F);
      check({30'h0, vref_on, capture_flush, playback_flush}, 33'h3);
      apb(1'b1, pwr_ctl_pkg::ADDR_TOTAL_PWR, 32'h0);
      rdx(pwr_ctl_pkg::ADDR_TEST_INIT, 33'h80, ALL);
      wait_init();
      apb(1'b1, pwr_ctl_pkg::ADDR_PWR_CTL, 32'h0);
      v1 = cal_offset_in;
      apb(1'b1, pwr_ctl_pkg::ADDR_IFACE_CFG, 32'h0);
      cal_check();
      check({29'h0, vref_on, adc_on, dac_on, mixer_on}, 33'hF);
      apb(1'b1, pwr_ctl_pkg::ADDR_OFFSET, 32'h0);
      rdx(pwr_ctl_pkg::ADDR_OFFSET, {17'h0, v1}, 33'hFFFF);
      // each software mode, then a full restore
      for (i = 0; i < 6; i++) begin
         apb(1'b1, pwr_ctl_pkg::ADDR_PWR_CTL, {29'h0, mtab[i][9:7]});
         ticks(2);
         rdx(pwr_ctl_pkg::ADDR_STATUS, {29'h0, mtab[i][6:3]}, 33'hF);
         check({30'h0, adc_on, dac_on, mixer_on}, {30'h0, mtab[i][2:0]});
         apb(1'b1, pwr_ctl_pkg::ADDR_PWR_CTL, 32'h0);
         ticks(2);
         check({29'h0, outputs_mute, adc_on, dac_on, mixer_on}, 33'hF);
         ticks(98);
         check({32'h0, outputs_mute}, 33'h1);
         ticks(35);
         check({32'h0, outputs_mute}, 33'h0);
      end
      apb(1'b1, pwr_ctl_pkg::ADDR_TOTAL_PWR, 32'h1);
      rdx(pwr_ctl_pkg::ADDR_STATUS, 33'h20, 33'h70);
      cal_offset_in <= 16'($random(seed));
      apb(1'b1, pwr_ctl_pkg::ADDR_IFACE_CFG, 32'h1);
      apb(1'b1, pwr_ctl_pkg::ADDR_IFACE_CFG, 32'h0);
      rdx(pwr_ctl_pkg::ADDR_TEST_INIT, 33'h0, 33'h20);
      rdx(pwr_ctl_pkg::ADDR_OFFSET, {17'h0, v1}, 33'hFFFF);
      // requested calibration, capture enabled
      apb(1'b1, pwr_ctl_pkg::ADDR_IFACE_CFG, 32'h3);
      apb(1'b1, pwr_ctl_pkg::ADDR_IFACE_CFG, 32'h6);
      check({31'h0, capture_run, capture_data_valid}, 33'h0);
      cal_check();
      check({32'h0, capture_run}, 33'h1);
      rdx(pwr_ctl_pkg::ADDR_OFFSET, {17'h0, cal_offset_in}, 33'hFFFF);
      hw_sleep_pin_n <= 1'b0;
      repeat (3) @(posedge pclk);
      hw_sleep_pin_n <= 1'b1;
      rdx(pwr_ctl_pkg::ADDR_TEST_INIT, 33'h80, ALL);
      wait_init();
      rdx(pwr_ctl_pkg::ADDR_IFACE_CFG, 33'h1, 33'hF);
      test_done();
   end
endmodule : tb_codec_power_ctl

`default_nettype wire
